// >>> daos_pkg.sv
// constants, register map and carrier types for direction and overtravel stop
// assumes a 32-bit apb register bus and a single 25 mhz clock

package daos_pkg;

    // -------------------------------------------------------------
    // register byte offsets
    // -------------------------------------------------------------
    localparam logic [7:0] CFG_OFS  = 8'h00;
    localparam logic [7:0] MAP_OFS  = 8'h04;
    localparam logic [7:0] EST_OFS  = 8'h08;
    localparam logic [7:0] MAXT_OFS = 8'h0C;
    localparam logic [7:0] STAT_OFS = 8'h10;

    // -------------------------------------------------------------
    // field positions
    // -------------------------------------------------------------
    localparam int CFG_DIR_BIT  = 0;
    localparam int CFG_OT_LSB   = 4;
    localparam int CFG_SV_LSB   = 8;
    localparam int CFG_TRQ_BIT  = 12;
    localparam int MAP_FWD_LSB  = 0;
    localparam int MAP_REV_LSB  = 4;
    localparam int TRQ_W        = 10;

    // -------------------------------------------------------------
    // mapping codes and reset values
    // -------------------------------------------------------------
    localparam logic [3:0] FWD_MAP_PIN = 4'h2;
    localparam logic [3:0] REV_MAP_PIN = 4'h3;
    localparam logic [3:0] MAP_UNUSED  = 4'h8;
    localparam logic [3:0] FWD_MAP_INV = 4'hB;
    localparam logic [3:0] REV_MAP_INV = 4'hC;
    localparam logic [TRQ_W-1:0] EST_RST  = 10'h320;
    localparam logic [TRQ_W-1:0] MAXT_RST = 10'h320;

    // overtravel stop selections
    localparam logic [1:0] OT_AS_SVOFF = 2'h0;
    localparam logic [1:0] OT_CLAMP    = 2'h1;
    localparam logic [1:0] OT_COAST    = 2'h2;

    // -------------------------------------------------------------
    // types
    // -------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_RUN   = 3'b000,
        ST_SVDEC = 3'b001,
        ST_EDEC  = 3'b010,
        ST_CLAMP = 3'b011,
        ST_COAST = 3'b100
    } daos_state_t;

    typedef struct packed {
        logic       torque_ctrl;
        logic [1:0] servo_off_stop_select;
        logic [1:0] overtravel_stop_select;
        logic       direction_select;
    } daos_cfg_t;

    typedef struct packed {
        logic [3:0] rev_limit_mapping;
        logic [3:0] fwd_limit_mapping;
    } daos_map_t;

endpackage : daos_pkg

// >>> daos_top.sv
// direction selection and overtravel stop control with apb registers
// assumes apb master on pclk, limit switch pins asynchronous to pclk,
// host motion commands and motor-stopped flag synchronous to pclk
//
// The implementer's own choices: the address map and the APB slave port.

`timescale 1ns/1ps
`default_nettype none

module daos_top (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    // limit switch pins
    input  wire logic        fwd_travel_limit_in,
    input  wire logic        rev_travel_limit_in,
    // host motion interface
    input  wire logic        servo_on,
    input  wire logic        cmd_fwd,
    input  wire logic        cmd_rev,
    input  wire logic        motor_stopped,
    // motor drive outputs
    output var  logic        drive_fwd,
    output var  logic        drive_rev,
    output var  logic        motor_cw,
    output var  logic        decel,
    output var  logic        zero_clamp,
    output var  logic        coast,
    output var  logic [9:0]  stop_torque
);

    // -------------------------------------------------------------
    // registers and state
    // -------------------------------------------------------------
    daos_pkg::daos_cfg_t   cfg_q;
    daos_pkg::daos_map_t   map_q;
    daos_pkg::daos_state_t state_q;
    logic [9:0]  est_q;
    logic [9:0]  maxt_q;
    logic [1:0]  fwd_sync_q;
    logic [1:0]  rev_sync_q;
    logic        fwd_ok_q;
    logic        rev_ok_q;
    logic        fwd_ok_d;
    logic        rev_ok_d;
    logic        ot_hit;
    logic        est_mode;
    logic [9:0]  est_lim;
    logic [31:0] rd_d;
    logic        hit_d;
    logic        wr_en;

    // -------------------------------------------------------------
    // limit pin synchronisers
    // -------------------------------------------------------------
    // two stages: only the second stage feeds the mapping logic
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fwd_sync_q <= 2'h0;
            rev_sync_q <= 2'h0;
        end else begin
            fwd_sync_q <= {fwd_sync_q[0], fwd_travel_limit_in};
            rev_sync_q <= {rev_sync_q[0], rev_travel_limit_in};
        end
    end

    // -------------------------------------------------------------
    // limit mapping
    // -------------------------------------------------------------
    // unlisted mapping codes behave as unused so motion is never
    // blocked by a half-configured terminal
    always_comb begin
        case (map_q.fwd_limit_mapping)
            daos_pkg::FWD_MAP_PIN: fwd_ok_d = !fwd_sync_q[1];
            daos_pkg::FWD_MAP_INV: fwd_ok_d = fwd_sync_q[1];
            default:               fwd_ok_d = 1'b1;
        endcase
        case (map_q.rev_limit_mapping)
            daos_pkg::REV_MAP_PIN: rev_ok_d = !rev_sync_q[1];
            daos_pkg::REV_MAP_INV: rev_ok_d = rev_sync_q[1];
            default:               rev_ok_d = 1'b1;
        endcase
    end

    // registered permission flags
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fwd_ok_q <= 1'b1;
            rev_ok_q <= 1'b1;
        end else begin
            fwd_ok_q <= fwd_ok_d;
            rev_ok_q <= rev_ok_d;
        end
    end

    // -------------------------------------------------------------
    // overtravel stop sequencer
    // -------------------------------------------------------------
    // a prohibited command only trips while the servo is on
    assign ot_hit = servo_on &&
                    ((cmd_fwd && !fwd_ok_q) || (cmd_rev && !rev_ok_q));
    assign est_mode = !cfg_q.torque_ctrl &&
        (cfg_q.overtravel_stop_select == daos_pkg::OT_CLAMP ||
         cfg_q.overtravel_stop_select == daos_pkg::OT_COAST);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= daos_pkg::ST_RUN;
        end else begin
            case (state_q)
                daos_pkg::ST_RUN: begin
                    if (ot_hit && est_mode) begin
                        state_q <= daos_pkg::ST_EDEC;
                    end else if (ot_hit &&
                                 cfg_q.servo_off_stop_select == 2'h0) begin
                        state_q <= daos_pkg::ST_SVDEC;
                    end else if (ot_hit) begin
                        state_q <= daos_pkg::ST_COAST;
                    end
                end
                daos_pkg::ST_SVDEC: begin
                    if (motor_stopped) begin
                        state_q <= daos_pkg::ST_COAST;
                    end
                end
                daos_pkg::ST_EDEC: begin
                    if (motor_stopped &&
                        cfg_q.overtravel_stop_select == daos_pkg::OT_CLAMP)
                    begin
                        state_q <= daos_pkg::ST_CLAMP;
                    end else if (motor_stopped) begin
                        state_q <= daos_pkg::ST_COAST;
                    end
                end
                daos_pkg::ST_CLAMP, daos_pkg::ST_COAST: begin
                    if (!ot_hit) begin
                        state_q <= daos_pkg::ST_RUN;
                    end
                end
                default: state_q <= daos_pkg::ST_RUN;
            endcase
        end
    end

    // -------------------------------------------------------------
    // drive outputs
    // -------------------------------------------------------------
    // stop torque is clamped to the motor maximum
    assign est_lim = (est_q > maxt_q) ? maxt_q : est_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            drive_fwd   <= 1'b0;
            drive_rev   <= 1'b0;
            decel       <= 1'b0;
            zero_clamp  <= 1'b0;
            coast       <= 1'b0;
            stop_torque <= 10'h000;
        end else begin
            drive_fwd  <= state_q == daos_pkg::ST_RUN && servo_on &&
                          cmd_fwd && !cmd_rev && fwd_ok_q;
            drive_rev  <= state_q == daos_pkg::ST_RUN && servo_on &&
                          cmd_rev && !cmd_fwd && rev_ok_q;
            decel      <= state_q == daos_pkg::ST_EDEC ||
                          state_q == daos_pkg::ST_SVDEC;
            zero_clamp <= state_q == daos_pkg::ST_CLAMP;
            coast      <= state_q == daos_pkg::ST_COAST;
            stop_torque <= (state_q == daos_pkg::ST_EDEC) ?
                           est_lim : 10'h000;
        end
    end

    // shaft sign only: limits and mapping stay in reference terms
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            motor_cw <= 1'b0;
        end else if (drive_fwd) begin
            motor_cw <= cfg_q.direction_select;
        end else if (drive_rev) begin
            motor_cw <= !cfg_q.direction_select;
        end
    end

    // -------------------------------------------------------------
    // apb register file
    // -------------------------------------------------------------
    // no wait state: read data and pready are registered in setup
    assign wr_en = psel && penable && pready && pwrite && !pslverr;

    always_comb begin
        rd_d  = 32'h0000_0000;
        hit_d = 1'b1;
        case (paddr)
            daos_pkg::CFG_OFS: begin
                rd_d[daos_pkg::CFG_DIR_BIT] = cfg_q.direction_select;
                rd_d[daos_pkg::CFG_OT_LSB +: 2] =
                    cfg_q.overtravel_stop_select;
                rd_d[daos_pkg::CFG_SV_LSB +: 2] =
                    cfg_q.servo_off_stop_select;
                rd_d[daos_pkg::CFG_TRQ_BIT] = cfg_q.torque_ctrl;
            end
            daos_pkg::MAP_OFS:  rd_d[7:0] = map_q;
            daos_pkg::EST_OFS:  rd_d[9:0] = est_q;
            daos_pkg::MAXT_OFS: rd_d[9:0] = maxt_q;
            daos_pkg::STAT_OFS: begin
                rd_d[0]   = fwd_ok_q;
                rd_d[1]   = rev_ok_q;
                rd_d[2]   = fwd_sync_q[1];
                rd_d[3]   = rev_sync_q[1];
                rd_d[6:4] = state_q;
                rd_d[8]   = motor_cw;
            end
            default: hit_d = 1'b0;
        endcase
    end

    // bus handshake
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else if (psel && !penable) begin
            prdata  <= pwrite ? 32'h0000_0000 : rd_d;
            pready  <= 1'b1;
            pslverr <= !hit_d || (pwrite && paddr == daos_pkg::STAT_OFS);
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // writable settings
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_q  <= '0;
            map_q  <= {daos_pkg::MAP_UNUSED, daos_pkg::MAP_UNUSED};
            est_q  <= daos_pkg::EST_RST;
            maxt_q <= daos_pkg::MAXT_RST;
        end else if (wr_en) begin
            case (paddr)
                daos_pkg::CFG_OFS: begin
                    cfg_q.direction_select <=
                        pwdata[daos_pkg::CFG_DIR_BIT];
                    cfg_q.overtravel_stop_select <=
                        pwdata[daos_pkg::CFG_OT_LSB +: 2];
                    cfg_q.servo_off_stop_select <=
                        pwdata[daos_pkg::CFG_SV_LSB +: 2];
                    cfg_q.torque_ctrl <= pwdata[daos_pkg::CFG_TRQ_BIT];
                end
                daos_pkg::MAP_OFS:  map_q  <= pwdata[7:0];
                daos_pkg::EST_OFS:  est_q  <= pwdata[9:0];
                daos_pkg::MAXT_OFS: maxt_q <= pwdata[9:0];
                default: ;
            endcase
        end
    end

    // -------------------------------------------------------------
    // assertions
    // -------------------------------------------------------------
    AST_FWD_CCW: assert property (
        @(posedge pclk) disable iff (!presetn)
        (drive_fwd && !cfg_q.direction_select) |=> !motor_cw)
        else $error("forward not ccw in standard mode");

    AST_FWD_CW: assert property (
        @(posedge pclk) disable iff (!presetn)
        (drive_fwd && cfg_q.direction_select) |=> motor_cw)
        else $error("forward not cw in reverse mode");

    AST_REV_SIGN: assert property (
        @(posedge pclk) disable iff (!presetn)
        (drive_rev && !drive_fwd) |=>
        motor_cw != $past(cfg_q.direction_select))
        else $error("reverse sign wrong");

    AST_FWD_PIN: assert property (
        @(posedge pclk) disable iff (!presetn)
        (map_q.fwd_limit_mapping == daos_pkg::FWD_MAP_PIN &&
         $stable(map_q)) |=> fwd_ok_q == !$past(fwd_sync_q[1]))
        else $error("forward pin mapping wrong");

    AST_FWD_INV: assert property (
        @(posedge pclk) disable iff (!presetn)
        (map_q.fwd_limit_mapping == daos_pkg::FWD_MAP_INV &&
         $stable(map_q)) |=> fwd_ok_q == $past(fwd_sync_q[1]))
        else $error("forward inverted mapping wrong");

    AST_FWD_UNUSED: assert property (
        @(posedge pclk) disable iff (!presetn)
        (map_q.fwd_limit_mapping == daos_pkg::MAP_UNUSED) |=> fwd_ok_q)
        else $error("unused forward limit blocked motion");

    AST_REV_MAP: assert property (
        @(posedge pclk) disable iff (!presetn)
        (map_q.rev_limit_mapping == daos_pkg::REV_MAP_PIN &&
         $stable(map_q)) ##1
        (rev_sync_q[1] && map_q.rev_limit_mapping == daos_pkg::REV_MAP_PIN)
        |=> !rev_ok_q ##1 !drive_rev)
        else $error("reverse pin mapping wrong");

    AST_EDEC_CLAMP: assert property (
        @(posedge pclk) disable iff (!presetn)
        (state_q == daos_pkg::ST_EDEC && motor_stopped &&
         cfg_q.overtravel_stop_select == daos_pkg::OT_CLAMP)
        |=> state_q == daos_pkg::ST_CLAMP ##1 zero_clamp)
        else $error("no zero clamp after decel");

    AST_EDEC_COAST: assert property (
        @(posedge pclk) disable iff (!presetn)
        (state_q == daos_pkg::ST_EDEC && motor_stopped &&
         cfg_q.overtravel_stop_select == daos_pkg::OT_COAST)
        |=> state_q == daos_pkg::ST_COAST ##1 coast)
        else $error("no coast after decel");

    AST_TRQ_NOCLAMP: assert property (
        @(posedge pclk) disable iff (!presetn)
        (state_q == daos_pkg::ST_RUN && ot_hit && cfg_q.torque_ctrl)
        |=> state_q != daos_pkg::ST_EDEC)
        else $error("torque control used stop select");

    AST_EST_ONLY: assert property (
        @(posedge pclk) disable iff (!presetn)
        (stop_torque != 10'h000) |-> $past(state_q == daos_pkg::ST_EDEC))
        else $error("stop torque outside emergency decel");

    AST_EST_MAX: assert property (
        @(posedge pclk) disable iff (!presetn)
        $past(state_q == daos_pkg::ST_EDEC) |->
        stop_torque == $past(est_lim) && stop_torque <= $past(maxt_q))
        else $error("stop torque above motor maximum");

endmodule : daos_top

`default_nettype wire

// >>> daos_limit_model.sv
// limit switches and motor stand-in for the overtravel stop block
// assumes the bench opens and closes the switches and sets run-down time
`timescale 1ns/1ps
`default_nettype none

module daos_limit_model (
    // clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // bench commands
    input  wire logic       fwd_open,
    input  wire logic       rev_open,
    input  wire logic [2:0] stop_cyc,
    // drive seen from the block
    input  wire logic       drive_fwd,
    input  wire logic       drive_rev,
    input  wire logic       decel,
    input  wire logic       coast,
    // pins and motor feedback
    output var  logic       fwd_travel_limit_in,
    output var  logic       rev_travel_limit_in,
    output var  logic       motor_stopped
);
    logic       moving_q;
    logic [2:0] run_down_q;

    // open contact is pulled up, a closed one grounds the pin
    assign fwd_travel_limit_in = fwd_open;
    assign rev_travel_limit_in = rev_open;
    assign motor_stopped       = !moving_q;

    // spins while granted; runs down slowly or promptly per stop_cyc
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            moving_q   <= 1'b0;
            run_down_q <= 3'h0;
        end else if (drive_fwd || drive_rev) begin
            moving_q   <= 1'b1;
            run_down_q <= 3'h0;
        end else if (moving_q && (decel || coast)) begin
            if (run_down_q >= stop_cyc) begin
                moving_q <= 1'b0;
            end
            run_down_q <= run_down_q + 3'h1;
        end
    end
endmodule : daos_limit_model

`default_nettype wire

// >>> daos_tb_top.sv
// self-checking bench for the direction and overtravel stop block
// assumes daos_limit_model stands in for the switches and the motor
`timescale 1ns/1ps
`default_nettype none

module daos_tb_top;
    logic        pclk = 1'b0;
    logic        presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, r;
    logic        servo_on, cmd_fwd, cmd_rev, motor_stopped, s;
    logic        fwd_travel_limit_in, rev_travel_limit_in;
    logic        drive_fwd, drive_rev, motor_cw, decel, zero_clamp, coast;
    logic [9:0]  stop_torque;
    logic        fwd_open, rev_open, fp, rp;
    logic [2:0]  stop_cyc;
    logic [3:0]  fc, rc;
    int          err_count, tests_run, i;
    logic [3:0]  fcodes [3] = '{daos_pkg::FWD_MAP_PIN,
                                daos_pkg::MAP_UNUSED, daos_pkg::FWD_MAP_INV};
    logic [3:0]  rcodes [3] = '{daos_pkg::REV_MAP_PIN,
                                daos_pkg::MAP_UNUSED, daos_pkg::REV_MAP_INV};

    daos_top u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .fwd_travel_limit_in,
        .rev_travel_limit_in, .servo_on, .cmd_fwd, .cmd_rev, .motor_stopped,
        .drive_fwd, .drive_rev, .motor_cw, .decel, .zero_clamp, .coast,
        .stop_torque);
    daos_limit_model u_model (.pclk, .presetn, .fwd_open, .rev_open,
        .stop_cyc, .drive_fwd, .drive_rev, .decel, .coast,
        .fwd_travel_limit_in, .rev_travel_limit_in, .motor_stopped);

    // -------------------------------------------------------------
    // helpers
    // -------------------------------------------------------------
    always #20 pclk = ~pclk;

    task automatic close_out();
        if (err_count == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : close_out

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask : cyc

    // one apb transfer; leaves an idle cycle so psel is never reassigned
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) err_count++;
        r = prdata;
        s = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    function automatic logic okf(input logic [3:0] c, input logic p,
                                 input logic [3:0] pc, input logic [3:0] ic);
        return (c == pc) ? !p : (c == ic) ? p : 1'b1;
    endfunction : okf

    // stop torque is clipped at the motor maximum
    function automatic logic [9:0] tqf(input logic [9:0] e);
        return (e > daos_pkg::MAXT_RST) ? daos_pkg::MAXT_RST : e;
    endfunction : tqf

    // run forward, open the forward switch, watch the stop sequence
    task automatic trip(input int sel, input int sv, input int tq);
        logic [9:0] est, got;
        logic       seen_dec, edec;
        int         n;
        est = 10'($urandom_range(0, 1023));
        stop_cyc <= 3'($urandom_range(0, 7));
        // close the switch first: its synced level must settle before motion
        fwd_open <= 1'b0;
        apb(1'b1, daos_pkg::CFG_OFS, (tq << daos_pkg::CFG_TRQ_BIT) |
            (sv << daos_pkg::CFG_SV_LSB) | (sel << daos_pkg::CFG_OT_LSB));
        apb(1'b1, daos_pkg::MAP_OFS, 32'h00000082);
        apb(1'b1, daos_pkg::EST_OFS, {22'h0, est});
        servo_on <= 1'b1;
        cmd_fwd  <= 1'b1;
        cyc(6);
        chk(drive_fwd, 1);
        fwd_open <= 1'b1;
        seen_dec = 1'b0;
        got = 10'h0;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
            if (decel === 1'b1) begin
                seen_dec = 1'b1;
                got = stop_torque;
            end
        end while (zero_clamp !== 1'b1 && coast !== 1'b1 && n < 60);
        edec = (tq == 0) && (sel != 0);
        chk(drive_fwd, 0);
        chk(seen_dec, edec || sv == 0);
        chk(got, edec ? tqf(est) : 10'h0);
        chk(zero_clamp, edec && sel == 1);
        chk(coast, !(edec && sel == 1));
        cmd_fwd  <= 1'b0;
        fwd_open <= 1'b0;
        cyc(4);
        chk({zero_clamp, coast, decel}, 3'h0);
    endtask : trip

    // -------------------------------------------------------------
    // main sequence
    // -------------------------------------------------------------
    initial begin
        {presetn, psel, penable, pwrite, servo_on} = 5'h00;
        {cmd_fwd, cmd_rev, fwd_open, rev_open} = 4'h0;
        {paddr, pwdata, stop_cyc} = 43'h0;
        err_count = 0;
        tests_run = 0;
        void'($urandom(43389));
        cyc(3);
        presetn <= 1'b1;
        cyc(1);
        // reset values and refused accesses
        apb(1'b0, daos_pkg::CFG_OFS, 32'h0);
        chk(r, 32'h0);
        apb(1'b0, daos_pkg::MAP_OFS, 32'h0);
        chk(r, 32'h00000088);
        apb(1'b0, daos_pkg::EST_OFS, 32'h0);
        chk(r, 32'h00000320);
        apb(1'b0, 8'h14, 32'h0);
        chk({31'h0, s}, 32'h1);
        chk(r, 32'h0);
        apb(1'b1, daos_pkg::STAT_OFS, 32'hFFFFFFFF);
        chk(s, 1'b1);
        // rotating forward and random reverse mapping codes against random switch levels
        for (i = 0; i < 16; i++) begin
            fc = fcodes[i % 3];
            rc = rcodes[$urandom_range(0, 2)];
            fp = 1'($urandom_range(0, 1));
            rp = 1'($urandom_range(0, 1));
            apb(1'b1, daos_pkg::MAP_OFS, {24'h0, rc, fc});
            fwd_open <= fp;
            rev_open <= rp;
            cyc(5);
            apb(1'b0, daos_pkg::STAT_OFS, 32'h0);
            chk(r[1:0], {okf(rc, rp, daos_pkg::REV_MAP_PIN,
                daos_pkg::REV_MAP_INV), okf(fc, fp, daos_pkg::FWD_MAP_PIN,
                daos_pkg::FWD_MAP_INV)});
        end
        // both directions, each with the opposite switch open
        apb(1'b1, daos_pkg::MAP_OFS, 32'h00000032);
        servo_on <= 1'b1;
        for (i = 0; i < 4; i++) begin
            apb(1'b1, daos_pkg::CFG_OFS, {31'h0, i[0]});
            fwd_open <= i[1];
            rev_open <= !i[1];
            cyc(6);
            cmd_fwd <= !i[1];
            cmd_rev <= i[1];
            cyc(3);
            chk({drive_fwd, drive_rev}, {!i[1], i[1]});
            chk(motor_cw, i[0] ^ i[1]);
            cmd_fwd <= 1'b0;
            cmd_rev <= 1'b0;
            cyc(2);
        end
        // every stop selection, servo-off selection and control mode
        for (i = 0; i < 12; i++) trip(i % 3, (i / 3) % 2, i / 6);
        close_out();
    end

    // watchdog far beyond the expected several hundred cycles
    initial begin
        #400000;
        err_count++;
        close_out();
    end
endmodule : daos_tb_top

`default_nettype wire
